// ---- hw/csl_defines.svh ----
// Command opcodes and widths shared by the co-simulation slave lifecycle logic
`ifndef CSL_DEFINES_SVH
`define CSL_DEFINES_SVH

`define CSL_OP_W            8
`define CSL_OP_REGISTER     8'h01
`define CSL_OP_PREPARE      8'h02
`define CSL_OP_DEREGISTER   8'h03
`define CSL_OP_CONFIGURE    8'h04
`define CSL_OP_INITIALIZE   8'h05
`define CSL_OP_STOP         8'h06
`define CSL_SYNC_RST        1'b0

`endif

// ---- hw/csl_pkg.sv ----
// Types for the co-simulation slave lifecycle logic
package csl_pkg;

    typedef enum logic [3:0]
    {
        CSL_ST_ENTRY,
        CSL_ST_ALIVE,
        CSL_ST_CONFIGURATION,
        CSL_ST_PREPARING,
        CSL_ST_PREPARED,
        CSL_ST_CONFIGURING,
        CSL_ST_CONFIGURED,
        CSL_ST_INITIALIZING,
        CSL_ST_STOPPED,
        CSL_ST_ERRHANDLING,
        CSL_ST_ERRRESOLVED,
        CSL_ST_EXITED
    } csl_state_t;

    typedef enum logic [2:0]
    {
        CSL_CMD_NONE,
        CSL_CMD_REGISTER,
        CSL_CMD_PREPARE,
        CSL_CMD_DEREGISTER,
        CSL_CMD_CONFIGURE,
        CSL_CMD_INITIALIZE,
        CSL_CMD_STOP,
        CSL_CMD_UNKNOWN
    } csl_cmd_t;

endpackage

// ---- hw/csl_pin_sync.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`include "csl_defines.svh"

module csl_pin_sync
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic pinIn,
    output logic      levelOut
);

    logic stage1_ff;
    logic stage2_ff;
    logic stage3_ff;
    logic level_ff;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            stage1_ff <= `CSL_SYNC_RST;
            stage2_ff <= `CSL_SYNC_RST;
            stage3_ff <= `CSL_SYNC_RST;
        end
        else
        begin
            stage1_ff <= pinIn;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
        end
    end

    // Only stages two and three vote, stage one is left to settle
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            level_ff <= `CSL_SYNC_RST;
        else if (stage2_ff == stage3_ff)
            level_ff <= stage3_ff;
    end

    assign levelOut = level_ff;

endmodule

// ---- hw/csl_cmd_decode.sv ----
// Registers a state-change command and decodes its opcode
`timescale 1ns/1ps
`include "csl_defines.svh"

module csl_cmd_decode
    import csl_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 cmdValid,
    input  wire logic [`CSL_OP_W-1:0] cmdCode,
    output csl_cmd_t                  cmdKind,
    output logic                      cmdStrobe
);

    csl_cmd_t kind_ff;
    logic     strobe_ff;

    function automatic csl_cmd_t decodeOp(input logic [`CSL_OP_W-1:0] op);
        case (op)
            `CSL_OP_REGISTER:   decodeOp = CSL_CMD_REGISTER;
            `CSL_OP_PREPARE:    decodeOp = CSL_CMD_PREPARE;
            `CSL_OP_DEREGISTER: decodeOp = CSL_CMD_DEREGISTER;
            `CSL_OP_CONFIGURE:  decodeOp = CSL_CMD_CONFIGURE;
            `CSL_OP_INITIALIZE: decodeOp = CSL_CMD_INITIALIZE;
            `CSL_OP_STOP:       decodeOp = CSL_CMD_STOP;
            default:            decodeOp = CSL_CMD_UNKNOWN;
        endcase
    endfunction

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            kind_ff   <= CSL_CMD_NONE;
            strobe_ff <= 1'b0;
        end
        else
        begin
            strobe_ff <= cmdValid;
            kind_ff   <= cmdValid ? decodeOp(cmdCode) : CSL_CMD_NONE;
        end
    end

    assign cmdKind   = kind_ff;
    assign cmdStrobe = strobe_ff;

endmodule

// ---- hw/csl_lifecycle_fsm.sv ----
// Lifecycle state machine of a co-simulation slave
`timescale 1ns/1ps
`include "csl_defines.svh"

module csl_lifecycle_fsm
    import csl_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 cmdValid,
    input  wire logic [`CSL_OP_W-1:0] cmdCode,
    input  wire logic                 swLoaded,
    input  wire logic                 sigExit,
    input  wire logic                 faultPin,
    input  wire logic                 errHandled,
    input  wire logic                 errUnrecoverable,
    input  wire logic                 configComplete,
    input  wire logic                 sigPrepared,
    input  wire logic                 sigConfigured,
    output csl_state_t                stateOut,
    output logic                      registered,
    output logic                      safeHold,
    output logic                      prepTransport,
    output logic                      applyConfig,
    output logic                      initStart,
    output logic                      exited,
    output logic                      cmdRejected
);

    ////////////////////////////////////////////////////////////////////////////
    csl_state_t state_ff;
    csl_state_t nxt_state;
    csl_cmd_t   cmdKind;
    logic       cmdStrobe;
    logic       faultLevel;
    logic       faultLevel_ff;
    logic       faultEvt;
    logic       cmdTaken;
    logic       registered_ff;
    logic       nxt_registered;
    logic       safeHold_ff;
    logic       prepTransport_ff;
    logic       applyConfig_ff;
    logic       initStart_ff;
    logic       exited_ff;
    logic       cmdRejected_ff;
    logic       inErr;
    logic       inActive;

    csl_cmd_decode u_decode
    (
        .clock     (clock),
        .rst_n     (rst_n),
        .cmdValid  (cmdValid),
        .cmdCode   (cmdCode),
        .cmdKind   (cmdKind),
        .cmdStrobe (cmdStrobe)
    );

    // Fault comes from the model side on its own timing, hence the synchroniser
    csl_pin_sync u_faultSync
    (
        .clock    (clock),
        .rst_n    (rst_n),
        .pinIn    (faultPin),
        .levelOut (faultLevel)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            faultLevel_ff <= 1'b0;
        else
            faultLevel_ff <= faultLevel;
    end

    // A fault counts once, on its rising edge, so a long fault is not a second one
    assign faultEvt = faultLevel && !faultLevel_ff;

    assign inErr    = (state_ff == CSL_ST_ERRHANDLING) || (state_ff == CSL_ST_ERRRESOLVED);
    assign inActive = (state_ff != CSL_ST_ENTRY) && (state_ff != CSL_ST_EXITED) && !inErr;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        nxt_state = state_ff;
        cmdTaken  = 1'b0;
        if (state_ff == CSL_ST_ENTRY)
        begin
            if (swLoaded)
                nxt_state = CSL_ST_ALIVE;
        end
        else if (state_ff == CSL_ST_EXITED)
            nxt_state = CSL_ST_EXITED;
        else if (inErr && (faultEvt || sigExit || (state_ff == CSL_ST_ERRHANDLING && errUnrecoverable)))
            nxt_state = CSL_ST_EXITED;
        else if (faultEvt)
            nxt_state = CSL_ST_ERRHANDLING;
        else if (state_ff == CSL_ST_ALIVE && sigExit)
            nxt_state = CSL_ST_EXITED;
        else
        begin
            case (state_ff)
                CSL_ST_ALIVE:
                begin
                    if (cmdStrobe && cmdKind == CSL_CMD_REGISTER && !registered_ff)
                    begin
                        nxt_state = CSL_ST_CONFIGURATION;
                        cmdTaken  = 1'b1;
                    end
                end
                CSL_ST_CONFIGURATION:
                begin
                    if (cmdStrobe && cmdKind == CSL_CMD_PREPARE && configComplete)
                    begin
                        nxt_state = CSL_ST_PREPARING;
                        cmdTaken  = 1'b1;
                    end
                    else if (cmdStrobe && cmdKind == CSL_CMD_DEREGISTER && registered_ff)
                    begin
                        nxt_state = CSL_ST_ALIVE;
                        cmdTaken  = 1'b1;
                    end
                end
                CSL_ST_PREPARING:
                begin
                    if (cmdStrobe && cmdKind == CSL_CMD_STOP)
                    begin
                        nxt_state = CSL_ST_STOPPED;
                        cmdTaken  = 1'b1;
                    end
                    else if (sigPrepared)
                        nxt_state = CSL_ST_PREPARED;
                end
                CSL_ST_PREPARED:
                begin
                    if (cmdStrobe && cmdKind == CSL_CMD_CONFIGURE)
                    begin
                        nxt_state = CSL_ST_CONFIGURING;
                        cmdTaken  = 1'b1;
                    end
                    else if (cmdStrobe && cmdKind == CSL_CMD_STOP)
                    begin
                        nxt_state = CSL_ST_STOPPED;
                        cmdTaken  = 1'b1;
                    end
                end
                CSL_ST_CONFIGURING:
                begin
                    if (cmdStrobe && cmdKind == CSL_CMD_STOP)
                    begin
                        nxt_state = CSL_ST_STOPPED;
                        cmdTaken  = 1'b1;
                    end
                    else if (sigConfigured)
                        nxt_state = CSL_ST_CONFIGURED;
                end
                CSL_ST_CONFIGURED:
                begin
                    if (cmdStrobe && cmdKind == CSL_CMD_INITIALIZE)
                    begin
                        nxt_state = CSL_ST_INITIALIZING;
                        cmdTaken  = 1'b1;
                    end
                    else if (cmdStrobe && cmdKind == CSL_CMD_STOP)
                    begin
                        nxt_state = CSL_ST_STOPPED;
                        cmdTaken  = 1'b1;
                    end
                end
                CSL_ST_INITIALIZING:
                begin
                    if (cmdStrobe && cmdKind == CSL_CMD_STOP)
                    begin
                        nxt_state = CSL_ST_STOPPED;
                        cmdTaken  = 1'b1;
                    end
                end
                CSL_ST_STOPPED, CSL_ST_ERRRESOLVED:
                begin
                    if (cmdStrobe && cmdKind == CSL_CMD_DEREGISTER && registered_ff)
                    begin
                        nxt_state = CSL_ST_ALIVE;
                        cmdTaken  = 1'b1;
                    end
                end
                CSL_ST_ERRHANDLING:
                begin
                    if (errHandled)
                        nxt_state = CSL_ST_ERRRESOLVED;
                end
                default:
                    nxt_state = state_ff;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            state_ff <= CSL_ST_ENTRY;
        else
            state_ff <= nxt_state;
    end

    always_comb
    begin
        nxt_registered = registered_ff;
        if (nxt_state == CSL_ST_CONFIGURATION && state_ff == CSL_ST_ALIVE)
            nxt_registered = 1'b1;
        else if (nxt_state == CSL_ST_ALIVE || nxt_state == CSL_ST_EXITED)
            nxt_registered = 1'b0;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            registered_ff <= 1'b0;
        else
            registered_ff <= nxt_registered;
    end

    // Activity outputs follow the next state so they line up with stateOut
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            safeHold_ff      <= 1'b0;
            prepTransport_ff <= 1'b0;
            applyConfig_ff   <= 1'b0;
            initStart_ff     <= 1'b0;
            exited_ff        <= 1'b0;
        end
        else
        begin
            safeHold_ff      <= (nxt_state == CSL_ST_ERRHANDLING) || (nxt_state == CSL_ST_ERRRESOLVED);
            prepTransport_ff <= (nxt_state == CSL_ST_PREPARING);
            applyConfig_ff   <= (nxt_state == CSL_ST_CONFIGURING);
            initStart_ff     <= (nxt_state == CSL_ST_INITIALIZING);
            exited_ff        <= (nxt_state == CSL_ST_EXITED);
        end
    end

    // A command that finds no transition is flagged but otherwise dropped
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            cmdRejected_ff <= 1'b0;
        else
            cmdRejected_ff <= cmdStrobe && !cmdTaken;
    end

    assign stateOut      = state_ff;
    assign registered    = registered_ff;
    assign safeHold      = safeHold_ff;
    assign prepTransport = prepTransport_ff;
    assign applyConfig   = applyConfig_ff;
    assign initStart     = initStart_ff;
    assign exited        = exited_ff;
    assign cmdRejected   = cmdRejected_ff;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cbMain @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence sQuiet;
        !faultEvt && !sigExit;
    endsequence

    sequence sRegisterCmd;
        state_ff == CSL_ST_ALIVE && cmdStrobe && cmdKind == CSL_CMD_REGISTER && !registered_ff && !faultEvt && !sigExit;
    endsequence

    sequence sConfigured;
        state_ff == CSL_ST_CONFIGURATION && registered_ff;
    endsequence

    chk_fault_entry:
    assert property (faultEvt && inActive |=> state_ff == CSL_ST_ERRHANDLING && safeHold)
        else $error("fault did not lead to error handling");

    chk_error_resolve:
    assert property ((state_ff == CSL_ST_ERRHANDLING && errHandled && !errUnrecoverable) and sQuiet
                     |=> state_ff == CSL_ST_ERRRESOLVED)
        else $error("handled error did not resolve");

    chk_resolved_hold:
    assert property ((state_ff == CSL_ST_ERRRESOLVED && !(cmdStrobe && cmdKind == CSL_CMD_DEREGISTER)) and sQuiet
                     |=> state_ff == CSL_ST_ERRRESOLVED && safeHold)
        else $error("error resolved state left without cause");

    chk_entry_alive:
    assert property (state_ff == CSL_ST_ENTRY && swLoaded |=> state_ff == CSL_ST_ALIVE)
        else $error("software load did not reach alive");

    chk_exit_source:
    assert property (state_ff != CSL_ST_EXITED ##1 state_ff == CSL_ST_EXITED
                     |-> $past(state_ff) inside {CSL_ST_ALIVE, CSL_ST_ERRHANDLING, CSL_ST_ERRRESOLVED} && exited)
        else $error("exit taken from a forbidden state");

    chk_second_fault:
    assert property (inErr && faultEvt |=> state_ff == CSL_ST_EXITED ##1 state_ff == CSL_ST_EXITED [*2])
        else $error("second fault did not exit");

    chk_register_flow:
    assert property (sRegisterCmd |=> sConfigured)
        else $error("register command did not enter configuration");

    chk_prepare_flow:
    assert property (sConfigured ##0 ((cmdStrobe && cmdKind == CSL_CMD_PREPARE && configComplete) and sQuiet)
                     |=> state_ff == CSL_ST_PREPARING ##0 prepTransport)
        else $error("prepare command not taken");

    chk_prepared_sig:
    assert property (state_ff == CSL_ST_PREPARING && sigPrepared && !cmdStrobe && !faultEvt
                     |=> state_ff == CSL_ST_PREPARED && !prepTransport)
        else $error("prepared signal ignored");

    chk_deregister:
    assert property ((state_ff inside {CSL_ST_CONFIGURATION, CSL_ST_STOPPED, CSL_ST_ERRRESOLVED} && registered_ff
                     && cmdStrobe && cmdKind == CSL_CMD_DEREGISTER) and sQuiet
                     |=> state_ff == CSL_ST_ALIVE && !registered)
        else $error("deregister did not return to alive");

    chk_configure_cmd:
    assert property (state_ff == CSL_ST_PREPARED && cmdStrobe && cmdKind == CSL_CMD_CONFIGURE && !faultEvt
                     |=> state_ff == CSL_ST_CONFIGURING && applyConfig)
        else $error("configure command not taken");

    chk_configured_sig:
    assert property (state_ff == CSL_ST_CONFIGURING && sigConfigured && !cmdStrobe && !faultEvt
                     |=> state_ff == CSL_ST_CONFIGURED)
        else $error("configured signal ignored");

    chk_initialize_cmd:
    assert property (state_ff == CSL_ST_CONFIGURED && cmdStrobe && cmdKind == CSL_CMD_INITIALIZE && !faultEvt
                     |=> state_ff == CSL_ST_INITIALIZING && initStart)
        else $error("initialize command not taken");

    chk_reject_stable:
    assert property (cmdStrobe && !cmdTaken && inActive && !faultEvt && !sigExit && !sigPrepared && !sigConfigured
                     |=> $stable(state_ff) && cmdRejected)
        else $error("invalid command changed the state");

endmodule

// ---- tb/csl_master_model.sv ----
// Master model that issues one state-change command per call
`timescale 1ns/1ps
`include "csl_defines.svh"

module csl_master_model
(
    input  wire logic                 clock,
    output logic                      cmdValid,
    output logic [`CSL_OP_W-1:0]      cmdCode
);
    initial
    begin
        cmdValid = 1'b0;
        cmdCode  = 8'h5a;
    end

    // Valid for exactly one rising edge, changed only at falling edges
    task automatic issue(input logic [`CSL_OP_W-1:0] code);
        @(negedge clock);
        cmdValid = 1'b1;
        cmdCode  = code;
        @(negedge clock);
        cmdValid = 1'b0;
        // Code is not held after the strobe, so stale values never look like a command
        cmdCode  = ~code;
    endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the co-simulation slave lifecycle machine
`timescale 1ns/1ps
`include "csl_defines.svh"

module tb_top
    import csl_pkg::*;
;
    `define CHK(got, exp) begin nCompared++; if ((got) !== (exp)) begin nFail++; \
        $display("unexpected at %0t: got %h exp %h", $time, got, exp); end end

    logic clock, rst_n, swLoaded, sigExit, faultPin, errHandled, errUnrecoverable;
    logic configComplete, sigPrepared, sigConfigured, cmdValid;
    logic [7:0] cmdCode;
    logic registered, safeHold, prepTransport, applyConfig, initStart, exited, cmdRejected;
    csl_state_t stateOut, expState;
    logic regExp;
    int nFail, nCompared;
    logic [31:0] rnd;

    ////////////////////////////////////////////////////////////////////////////////
    csl_master_model u_master (.clock(clock), .cmdValid(cmdValid), .cmdCode(cmdCode));

    csl_lifecycle_fsm u_dut
    (
        .clock(clock), .rst_n(rst_n), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .swLoaded(swLoaded), .sigExit(sigExit), .faultPin(faultPin), .errHandled(errHandled),
        .errUnrecoverable(errUnrecoverable), .configComplete(configComplete),
        .sigPrepared(sigPrepared), .sigConfigured(sigConfigured), .stateOut(stateOut),
        .registered(registered), .safeHold(safeHold), .prepTransport(prepTransport),
        .applyConfig(applyConfig), .initStart(initStart), .exited(exited), .cmdRejected(cmdRejected)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Kind: 0 command, 1 prepared, 2 configured, 3 load, 4 fault, 5 handled, 6 unrecoverable, 7 exit
    function automatic csl_state_t expNext(csl_state_t s, logic [3:0] k, logic [7:0] op, logic cfg, logic rg);
        expNext = s;
        case (k)
            4'h0: case (op)
                `CSL_OP_REGISTER:   if (s == CSL_ST_ALIVE && !rg) expNext = CSL_ST_CONFIGURATION;
                `CSL_OP_PREPARE:    if (s == CSL_ST_CONFIGURATION && cfg) expNext = CSL_ST_PREPARING;
                `CSL_OP_DEREGISTER: if (rg && s inside {CSL_ST_CONFIGURATION, CSL_ST_STOPPED, CSL_ST_ERRRESOLVED})
                    expNext = CSL_ST_ALIVE;
                `CSL_OP_CONFIGURE:  if (s == CSL_ST_PREPARED) expNext = CSL_ST_CONFIGURING;
                `CSL_OP_INITIALIZE: if (s == CSL_ST_CONFIGURED) expNext = CSL_ST_INITIALIZING;
                `CSL_OP_STOP:       if (s inside {CSL_ST_PREPARING, CSL_ST_PREPARED, CSL_ST_CONFIGURING,
                    CSL_ST_CONFIGURED, CSL_ST_INITIALIZING}) expNext = CSL_ST_STOPPED;
                default: ;
            endcase
            4'h1: if (s == CSL_ST_PREPARING) expNext = CSL_ST_PREPARED;
            4'h2: if (s == CSL_ST_CONFIGURING) expNext = CSL_ST_CONFIGURED;
            4'h3: if (s == CSL_ST_ENTRY) expNext = CSL_ST_ALIVE;
            4'h4: if (s inside {CSL_ST_ERRHANDLING, CSL_ST_ERRRESOLVED}) expNext = CSL_ST_EXITED;
                else if (!(s inside {CSL_ST_ENTRY, CSL_ST_EXITED})) expNext = CSL_ST_ERRHANDLING;
            4'h5: if (s == CSL_ST_ERRHANDLING) expNext = CSL_ST_ERRRESOLVED;
            4'h6: if (s == CSL_ST_ERRHANDLING) expNext = CSL_ST_EXITED;
            4'h7: if (s inside {CSL_ST_ALIVE, CSL_ST_ERRHANDLING, CSL_ST_ERRRESOLVED})
                expNext = CSL_ST_EXITED;
            default: ;
        endcase
    endfunction

    task automatic setLocal(input logic [3:0] k, input logic v);
        case (k)
            4'h1: sigPrepared = v;
            4'h2: sigConfigured = v;
            4'h3: swLoaded = v;
            4'h4: faultPin = v;
            4'h5: errHandled = v;
            4'h6: errUnrecoverable = v;
            4'h7: sigExit = v;
            default: ;
        endcase
    endtask

    // Entry word: bit 12 configuration complete, bits 11:8 kind (8 = reset), bits 7:0 opcode
    task automatic step(input logic [15:0] e);
        logic [3:0] k;
        csl_state_t nxt;
        logic rejSeen;
        k = e[11:8];
        rejSeen = 1'b0;
        configComplete = e[12];
        if (k == 4'h8)
        begin
            rst_n = 1'b0;
            repeat (3) @(negedge clock);
            rst_n = 1'b1;
            expState = CSL_ST_ENTRY;
            regExp = 1'b0;
            return;
        end
        nxt = expNext(expState, k, e[7:0], e[12], regExp);
        if (k == 4'h0)
            u_master.issue(e[7:0]);
        else
        begin
            @(negedge clock);
            setLocal(k, 1'b1);
            // The fault pin passes a filtering synchroniser, so it must stay up a few cycles
            repeat ((k == 4'h4) ? 4 : 1) @(negedge clock);
            setLocal(k, 1'b0);
        end
        repeat (8)
        begin
            @(negedge clock);
            rejSeen = rejSeen | cmdRejected;
        end
        if (k == 4'h0 && e[7:0] == `CSL_OP_REGISTER && nxt != expState)
            regExp = 1'b1;
        if (nxt != expState && nxt inside {CSL_ST_ALIVE, CSL_ST_EXITED})
            regExp = 1'b0;
        `CHK(stateOut, nxt)
        `CHK(safeHold, nxt inside {CSL_ST_ERRHANDLING, CSL_ST_ERRRESOLVED})
        `CHK(prepTransport, nxt == CSL_ST_PREPARING)
        `CHK(applyConfig, nxt == CSL_ST_CONFIGURING)
        `CHK(initStart, nxt == CSL_ST_INITIALIZING)
        `CHK(exited, nxt == CSL_ST_EXITED)
        `CHK(registered, regExp)
        `CHK(rejSeen, k == 4'h0 && nxt == expState)
        expState = nxt;
    endtask

    task automatic tally_and_finish();
        if (nFail == 0 && nCompared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Corner walk: refusals, full configuration path, every error exit except a second fault during handling, then back to alive
    logic [15:0] dirTab [42] = '{
        16'h0001, 16'h0300, 16'h0003, 16'h0001, 16'h0001, 16'h0002, 16'h1002, 16'h0004,
        16'h0100, 16'h0004, 16'h0200, 16'h0005, 16'h00ff, 16'h0006, 16'h0003, 16'h0001,
        16'h0400, 16'h0500, 16'h0004, 16'h0003, 16'h0700, 16'h0300, 16'h0800, 16'h0300,
        16'h0001, 16'h0700, 16'h0400, 16'h0500, 16'h0400, 16'h0800, 16'h0300, 16'h0400,
        16'h0600, 16'h0800, 16'h0300, 16'h0400, 16'h0700, 16'h0800, 16'h0300, 16'h0400,
        16'h0500, 16'h0700
    };

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial
    begin
        #200us;
        nFail++;
        tally_and_finish();
    end

    initial
    begin
        logic [7:0] op;
        rst_n = 1'b0;
        {swLoaded, sigExit, faultPin, errHandled, errUnrecoverable} = '0;
        {configComplete, sigPrepared, sigConfigured} = '0;
        nFail = 0;
        nCompared = 0;
        expState = CSL_ST_ENTRY;
        regExp = 1'b0;
        rnd = 32'ha9427b19;
        repeat (8) @(negedge clock);
        rst_n = 1'b1;
        foreach (dirTab[i])
            step(dirTab[i]);
        step(16'h0800);
        step(16'h0300);
        repeat (150)
        begin
            rnd = xorshift(rnd);
            op = (rnd[3:0] < 4'hc) ? {5'h00, rnd[6:4]} : rnd[15:8];
            step({3'h0, rnd[20], (rnd[9:8] < 2'h2) ? 4'h0 : {2'h0, rnd[9:8] - 2'h1}, op});
        end
        tally_and_finish();
    end
endmodule
